//--- design/asrc_defines.svh
// Timing and geometry constants for the async SRAM host controller.
// Assumes a 10 MHz core clock (100 ns period).
`ifndef ASRC_DEFINES_SVH
`define ASRC_DEFINES_SVH
`define ASRC_CLK_NS        100
`define ASRC_ADDR_W        20
`define ASRC_DATA_W        16
`define ASRC_T_WP_NS       40
`define ASRC_T_AW_NS       50
`define ASRC_T_WC_NS       55
`define ASRC_T_RC_NS       70
`define ASRC_T_AA_NS       70
`define ASRC_T_BS_MS       5
`define ASRC_T_R_MS        5
`define ASRC_NS_PER_MS     1000000
`define ASRC_CNT_W         16
`endif

//--- design/asrc_pkg.sv
// Types shared by the async SRAM host controller.
// Assumes asrc_defines.svh is on the include path.
`include "asrc_defines.svh"
package asrc_pkg;
  typedef struct packed {
    logic                      write;
    logic                      byte_mode;
    logic [1:0]                lane_en;
    logic [`ASRC_ADDR_W-1:0]   addr;
    logic                      addr_lsb;
    logic [`ASRC_DATA_W-1:0]   wdata;
  } asrc_req_t;
  typedef enum logic [2:0] {
    ASRC_IDLE, ASRC_WRITE, ASRC_READ, ASRC_GAP, ASRC_MODE_WAIT, ASRC_RETAIN, ASRC_RECOVER
  } asrc_state_t;
endpackage

//--- design/asrc_host.sv
// Host-side controller for a 1M x16 / 2M x8 asynchronous static RAM.
// Assumes the user port is synchronous to core_clk and the SRAM sits on the pins.
// Contract
// - Byte mode keeps both lane selects low; an x16 request sets them from lane_en in the cycle the request is accepted
// - Address valid 50 ns before write end
// - Write pulse 40 ns, cycle 55 ns
// - Write data valid 25 ns before end
// - Byte mode stable 5 ms around accesses
// - Low-select retention holds high select firm
// - Deselect before retention, 5 ms recovery
`timescale 1ns/1ns
`default_nettype none
module asrc_host
  import asrc_pkg::*;
#(
  parameter int MODE_CYCLES    = (`ASRC_T_BS_MS * `ASRC_NS_PER_MS) / `ASRC_CLK_NS,
  parameter int RECOVER_CYCLES = (`ASRC_T_R_MS * `ASRC_NS_PER_MS) / `ASRC_CLK_NS
) (
  input  wire logic                     core_clk,
  input  wire logic                     rst,
  input  wire logic                     req_valid,
  input  wire asrc_req_t                req,
  output logic                          req_ready,
  output logic                          rsp_valid,
  output logic [`ASRC_DATA_W-1:0]       rsp_data,
  input  wire logic                     retain_req,
  output logic                          retained,
  output logic [`ASRC_ADDR_W-1:0]       word_address,
  output logic                          chip_select_low_active_n,
  output logic                          chip_select_high_active,
  output logic                          write_enable_n,
  output logic                          output_enable_n,
  output logic                          lower_lane_select_n,
  output logic                          upper_lane_select_n,
  output logic                          byte_mode_n,
  input  wire logic [7:0]               data_low_lanes_in,
  output logic [7:0]                    data_low_lanes_out,
  output logic                          data_low_lanes_oe,
  input  wire logic [6:0]               data_mid_upper_lanes_in,
  output logic [6:0]                    data_mid_upper_lanes_out,
  output logic                          data_mid_upper_lanes_oe,
  input  wire logic                     data_top_line_in,
  output logic                          data_top_line_out,
  output logic                          data_top_line_oe
);
  // Cycle counts derived from printed times (mins round up)
  localparam int WP_CYC = (`ASRC_T_WP_NS + `ASRC_CLK_NS - 1) / `ASRC_CLK_NS;
  localparam int AW_CYC = (`ASRC_T_AW_NS + `ASRC_CLK_NS - 1) / `ASRC_CLK_NS;
  localparam int WS_CYC = (WP_CYC > AW_CYC) ? WP_CYC : AW_CYC;
  localparam int WC_CYC = (`ASRC_T_WC_NS + `ASRC_CLK_NS - 1) / `ASRC_CLK_NS;
  localparam int RC_CYC = (`ASRC_T_RC_NS + `ASRC_CLK_NS - 1) / `ASRC_CLK_NS;
  localparam int GAP_CYC = (WC_CYC > WS_CYC) ? WC_CYC - WS_CYC : 1;

  asrc_state_t             state, next_state;
  logic [31:0]             cnt, next_cnt;
  asrc_req_t               cur, next_cur;
  logic                    next_req_ready, next_rsp_valid, next_retained;
  logic [`ASRC_DATA_W-1:0] next_rsp_data;
  logic [`ASRC_ADDR_W-1:0] next_word_address;
  logic next_cs_n, next_cs2, next_we_n, next_oe_n, next_lb_n, next_ub_n, next_byte_n;
  logic next_lo_oe, next_mid_oe, next_top_oe;
  logic [7:0]              next_lo_out;
  logic [6:0]              next_mid_out;
  logic                    next_top_out;

  // Sequencer: one access per request, none for a request that changes byte mode; pins set up in the same cycle as strobes
  always_comb begin
    next_state = state;
    next_cnt = (cnt == 32'h0) ? cnt : cnt - 32'h1;
    next_cur = cur;
    next_req_ready = 1'b0;
    next_rsp_valid = 1'b0;
    next_rsp_data = rsp_data;
    next_retained = retained;
    next_word_address = word_address;
    next_cs_n = chip_select_low_active_n;
    next_cs2 = chip_select_high_active;
    next_we_n = 1'b1;
    next_oe_n = 1'b1;
    next_lb_n = lower_lane_select_n;
    next_ub_n = upper_lane_select_n;
    next_byte_n = byte_mode_n;
    next_lo_oe = 1'b0;
    next_mid_oe = 1'b0;
    next_top_oe = data_top_line_oe;
    next_lo_out = data_low_lanes_out;
    next_mid_out = data_mid_upper_lanes_out;
    next_top_out = data_top_line_out;
    unique case (state)
      ASRC_IDLE: begin
        next_cs_n = 1'b1;
        next_top_oe = ~byte_mode_n;
        if (retain_req) begin
          next_cs2 = 1'b0;
          next_state = ASRC_RETAIN;
        end else if (req_valid && req_ready) begin
          next_cur = req;
          next_cs2 = 1'b1;
          next_word_address = req.addr;
          // Lane selects: both low in byte mode
          next_lb_n = req.byte_mode ? 1'b0 : ~req.lane_en[0];
          next_ub_n = req.byte_mode ? 1'b0 : ~req.lane_en[1];
          next_top_oe = req.byte_mode;
          next_top_out = req.addr_lsb;
          if (req.byte_mode != ~byte_mode_n) begin
            next_cnt = MODE_CYCLES;
            next_state = ASRC_MODE_WAIT;
          end else if (req.write) begin
            next_cs_n = 1'b0;
            next_we_n = 1'b0;
            next_lo_oe = 1'b1;
            next_mid_oe = ~req.byte_mode;
            next_lo_out = req.wdata[7:0];
            next_mid_out = req.wdata[14:8];
            if (!req.byte_mode) begin
              next_top_out = req.wdata[15];
              next_top_oe = 1'b1;
            end
            next_cnt = WS_CYC - 1;
            next_state = ASRC_WRITE;
          end else begin
            next_cs_n = 1'b0;
            next_oe_n = 1'b0;
            next_cnt = RC_CYC;
            next_state = ASRC_READ;
          end
        end else begin
          next_req_ready = 1'b1;
        end
      end
      // Mode pin flips only after a quiet wait, then waits again before use
      ASRC_MODE_WAIT: begin
        if (cnt == 32'h0) begin
          if (byte_mode_n == ~cur.byte_mode) begin
            next_state = ASRC_IDLE;
            next_req_ready = 1'b1;
          end else begin
            next_byte_n = ~cur.byte_mode;
            next_cnt = MODE_CYCLES;
          end
        end
      end
      ASRC_WRITE: begin
        next_cs_n = 1'b0;
        next_lo_oe = 1'b1;
        next_mid_oe = ~cur.byte_mode;
        if (cnt == 32'h0) begin
          next_we_n = 1'b1;
          next_cnt = GAP_CYC - 1;
          next_state = ASRC_GAP;
        end else begin
          next_we_n = 1'b0;
        end
      end
      ASRC_READ: begin
        next_cs_n = 1'b0;
        next_oe_n = 1'b0;
        if (cnt == 32'h0) begin
          next_rsp_valid = 1'b1;
          next_rsp_data = {data_top_line_in, data_mid_upper_lanes_in, data_low_lanes_in};
          if (cur.byte_mode)
            next_rsp_data = {8'h00, data_low_lanes_in};
          next_oe_n = 1'b1;
          next_cs_n = 1'b1;
          next_cnt = GAP_CYC - 1;
          next_state = ASRC_GAP;
        end
      end
      ASRC_GAP: begin
        next_cs_n = 1'b1;
        if (cnt == 32'h0) begin
          next_state = ASRC_IDLE;
          next_req_ready = 1'b1;
        end
      end
      ASRC_RETAIN: begin
        next_cs_n = 1'b1;
        next_cs2 = 1'b0;
        next_retained = 1'b1;
        if (!retain_req) begin
          next_cs2 = 1'b1;
          next_retained = 1'b0;
          next_cnt = RECOVER_CYCLES;
          next_state = ASRC_RECOVER;
        end
      end
      ASRC_RECOVER: begin
        if (cnt == 32'h0) begin
          next_state = ASRC_IDLE;
          next_req_ready = 1'b1;
        end
      end
    endcase
  end

  // State and pin registers
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state <= ASRC_IDLE;
      cnt <= 32'h0;
      cur <= '0;
      req_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_data <= 16'h0000;
      retained <= 1'b0;
      word_address <= 20'h00000;
      chip_select_low_active_n <= 1'b1;
      chip_select_high_active <= 1'b0;
      write_enable_n <= 1'b1;
      output_enable_n <= 1'b1;
      lower_lane_select_n <= 1'b1;
      upper_lane_select_n <= 1'b1;
      byte_mode_n <= 1'b1;
      data_low_lanes_oe <= 1'b0;
      data_mid_upper_lanes_oe <= 1'b0;
      data_top_line_oe <= 1'b0;
      data_low_lanes_out <= 8'h00;
      data_mid_upper_lanes_out <= 7'h00;
      data_top_line_out <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      cur <= next_cur;
      req_ready <= next_req_ready;
      rsp_valid <= next_rsp_valid;
      rsp_data <= next_rsp_data;
      retained <= next_retained;
      word_address <= next_word_address;
      chip_select_low_active_n <= next_cs_n;
      chip_select_high_active <= next_cs2;
      write_enable_n <= next_we_n;
      output_enable_n <= next_oe_n;
      lower_lane_select_n <= next_lb_n;
      upper_lane_select_n <= next_ub_n;
      byte_mode_n <= next_byte_n;
      data_low_lanes_oe <= next_lo_oe;
      data_mid_upper_lanes_oe <= next_mid_oe;
      data_top_line_oe <= next_top_oe;
      data_low_lanes_out <= next_lo_out;
      data_mid_upper_lanes_out <= next_mid_out;
      data_top_line_out <= next_top_out;
    end
  end
endmodule
`default_nettype wire

//--- tb/asrc_sram_model.sv
// Behavioural async SRAM on the far side of the host pins.
// Assumes the bench wires it to the split data pins of asrc_host.
`timescale 1ns/1ns
`default_nettype none
module asrc_sram_model (
  input  wire logic        clk,
  input  wire logic [19:0] wa,
  input  wire logic        csn,
  input  wire logic        cs2,
  input  wire logic        wen,
  input  wire logic        oen,
  input  wire logic        lbn,
  input  wire logic        ubn,
  input  wire logic        bmn,
  input  wire logic [7:0]  lo_o,
  input  wire logic        lo_e,
  input  wire logic [6:0]  mid_o,
  input  wire logic        mid_e,
  input  wire logic        top_o,
  input  wire logic        top_e,
  output logic      [7:0]  lo_i,
  output logic      [6:0]  mid_i,
  output logic             top_i
);
  logic [15:0] mem [0:1048575];
  logic [7:0]  bm [0:2097151];
  logic [15:0] q;
  logic        j = 1'b0;
  wire         x8 = !bmn;
  wire  [20:0] ba = {wa, top_o};
  wire         sel = !csn && cs2 && !(lbn && ubn);
  wire         wr = sel && !wen;
  wire         rd = sel && wen && !oen;
  // Store only when write enable is the first to release
  always @(negedge wr) begin
    if (sel && x8) bm[ba] = lo_o;
    if (sel && !x8 && !lbn) mem[wa][7:0] = lo_o;
    if (sel && !x8 && !ubn) mem[wa][15:8] = {top_o, mid_o};
  end
  // Zero-delay answer and release
  always @* q = x8 ? {8'h00, bm[ba]} : mem[wa];
  always @(posedge clk) j <= ~j;
  // Released lines toggle instead of holding
  assign lo_i = lo_e ? lo_o : (rd && !lbn ? q[7:0] : {8{j}});
  assign mid_i = mid_e ? mid_o : (rd && !ubn && !x8 ? q[14:8] : {7{j}});
  assign top_i = top_e ? top_o : (rd && !ubn && !x8 ? q[15] : j);
endmodule
`default_nettype wire

//--- tb/asrc_host_checker.sv
// Pin-level checks for the async SRAM host.
// Assumes it is bound onto asrc_host with matching parameters.
`timescale 1ns/1ns
`default_nettype none
module asrc_host_checker
  import asrc_pkg::*;
#(
  parameter int MODE_CYCLES    = 10,
  parameter int RECOVER_CYCLES = 10
) (
  input wire logic        core_clk,
  input wire logic        rst,
  input wire logic        req_ready,
  input wire logic        retained,
  input wire logic [19:0] word_address,
  input wire logic        chip_select_low_active_n,
  input wire logic        chip_select_high_active,
  input wire logic        write_enable_n,
  input wire logic        output_enable_n,
  input wire logic        lower_lane_select_n,
  input wire logic        upper_lane_select_n,
  input wire logic        byte_mode_n,
  input wire logic [7:0]  data_low_lanes_out,
  input wire logic        data_low_lanes_oe,
  input wire logic        data_mid_upper_lanes_oe,
  input wire logic        data_top_line_oe
);
  localparam int LIM = MODE_CYCLES < RECOVER_CYCLES ? MODE_CYCLES : RECOVER_CYCLES;
  logic [7:0] cnt;
  logic [7:0] next_cnt;
  logic       bm_q;
  wire        sel = !chip_select_low_active_n && chip_select_high_active;
  wire        wr = sel && !write_enable_n;
  // Cycles since mode change or retention
  always_comb begin
    next_cnt = (cnt == 8'hff) ? cnt : cnt + 8'h01;
    if (retained || byte_mode_n != bm_q) next_cnt = 8'h00;
  end
  always_ff @(posedge core_clk) begin
    cnt <= rst ? 8'hff : next_cnt;
    bm_q <= byte_mode_n;
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  a_byte_lanes: assert property (!byte_mode_n && sel |->
    !lower_lane_select_n && !upper_lane_select_n) else $error("lane select high in x8");
  a_addr_hold: assert property (wr |=> $stable(word_address))
    else $error("address moved at write end");
  a_data_hold: assert property (wr && !lower_lane_select_n |=>
    data_low_lanes_oe && $stable(data_low_lanes_out)) else $error("write data dropped");
  a_write_gap: assert property ($rose(write_enable_n) |-> write_enable_n [*2])
    else $error("write cycle too short");
  a_read_free: assert property (sel && write_enable_n && !output_enable_n |->
    !data_low_lanes_oe && !data_mid_upper_lanes_oe) else $error("bus fight in read");
  a_top_addr: assert property (!byte_mode_n && sel |-> data_top_line_oe)
    else $error("top line not driven in x8");
  a_retain_sel: assert property (retained |-> !chip_select_high_active)
    else $error("high select up in retention");
  a_ready_wait: assert property (req_ready |-> cnt >= LIM - 2)
    else $error("request accepted too early");
  c_write: cover property (wr);
  c_x8_write: cover property (wr && !byte_mode_n);
  c_retain: cover property ($fell(retained));
endmodule
bind asrc_host asrc_host_checker #(.MODE_CYCLES(MODE_CYCLES), .RECOVER_CYCLES(RECOVER_CYCLES))
  u_chk (.core_clk, .rst, .req_ready, .retained, .word_address, .chip_select_low_active_n,
  .chip_select_high_active, .write_enable_n, .output_enable_n, .lower_lane_select_n,
  .upper_lane_select_n, .byte_mode_n, .data_low_lanes_out, .data_low_lanes_oe,
  .data_mid_upper_lanes_oe, .data_top_line_oe);
`default_nettype wire

//--- tb/testbench.sv
// Self-checking bench for the async SRAM host.
// Assumes asrc_sram_model stands on the pins.
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin num_errors++; \
  $display("mismatch %0t got %h exp %h", $time, a, b); end end
module testbench;
  import asrc_pkg::*;
  logic core_clk = 0, rst = 1, req_valid = 0, retain_req = 0;
  asrc_req_t req = '0;
  logic req_ready, rsp_valid, retained, csn, cs2, wen, oen, lbn, ubn, bmn;
  logic top_o, top_i, lo_e, mid_e, top_e;
  logic [7:0] lo_o, lo_i;
  logic [6:0] mid_o, mid_i;
  logic [15:0] rsp_data, d, exp_d, sh [int], exq [$];
  logic [19:0] wa, a;
  int num_errors = 0, num_checks = 0, seed = 11, cyc = 0, i;
  always #50 core_clk = ~core_clk;
  asrc_host #(.MODE_CYCLES(10), .RECOVER_CYCLES(10)) u_dut (.core_clk, .rst, .req_valid,
    .req, .req_ready, .rsp_valid, .rsp_data, .retain_req, .retained, .word_address(wa),
    .chip_select_low_active_n(csn), .chip_select_high_active(cs2), .write_enable_n(wen),
    .output_enable_n(oen), .lower_lane_select_n(lbn), .upper_lane_select_n(ubn),
    .byte_mode_n(bmn), .data_low_lanes_in(lo_i), .data_low_lanes_out(lo_o),
    .data_low_lanes_oe(lo_e), .data_mid_upper_lanes_in(mid_i), .data_mid_upper_lanes_out(mid_o),
    .data_mid_upper_lanes_oe(mid_e), .data_top_line_in(top_i), .data_top_line_out(top_o),
    .data_top_line_oe(top_e));
  asrc_sram_model u_mem (.clk(core_clk), .wa, .csn, .cs2, .wen, .oen, .lbn, .ubn, .bmn,
    .lo_o, .lo_e, .mid_o, .mid_e, .top_o, .top_e, .lo_i, .mid_i, .top_i);
  task close_out;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Hold one request until it is taken
  task op(input logic w, m, input logic [1:0] l, input logic [19:0] ad, input logic s,
          input logic [15:0] wd);
    @(posedge core_clk);
    req_valid <= 1;
    req <= '{w, m, l, ad, s, wd};
    do @(negedge core_clk); while (req_ready !== 1'b1);
    @(posedge core_clk);
    req_valid <= 0;
  endtask
  task rd(input logic m, input logic [19:0] ad, input logic s, input logic [15:0] e);
    exq.push_back(e);
    op(0, m, 2'b11, ad, s, 16'h0000);
  endtask
  // Read results against the oldest note; hang guard
  always @(posedge core_clk) begin
    cyc++;
    if (cyc > 5000) begin
      num_errors++;
      close_out;
    end else if (rsp_valid === 1'b1) begin
      `CHK(exq.size() > 0, 1'b1)
      exp_d = exq.pop_front();
      `CHK(rsp_data, exp_d)
    end
  end
  // Main sequence
  initial begin
    repeat (12) @(posedge core_clk);
    rst <= 0;
    @(negedge core_clk) `CHK({csn, cs2, wen, oen, bmn}, 5'b10111)
    for (i = 0; i < 4; i++) begin
      a = 20'hfffff - 20'(i) * 20'h55555;
      d = 16'($random(seed));
      op(1, 0, 2'b11, a, 0, d);
      sh[a] = d;
    end
    for (i = 1; i < 3; i++) begin
      d = 16'($random(seed));
      op(1, 0, 2'(i), 20'h00000, 0, d);
      if (i == 1) sh[0][7:0] = d[7:0];
      else sh[0][15:8] = d[15:8];
    end
    for (i = 0; i < 4; i++) rd(0, 20'hfffff - 20'(i) * 20'h55555, 0, sh[20'hfffff - i * 'h55555]);
    op(1, 1, 2'b11, 20'h00000, 0, 16'h0000);
    for (i = 0; i < 4; i++) begin
      d = 16'($random(seed));
      op(1, 1, 2'b11, 20'(i >> 1), i[0], d);
      sh[32'h200000 + i] = d;
    end
    for (i = 0; i < 4; i++) rd(1, 20'(i >> 1), i[0], {8'h00, sh[32'h200000 + i][7:0]});
    op(1, 0, 2'b11, 20'h00000, 0, 16'h0000);
    do @(negedge core_clk); while (req_ready !== 1'b1);
    @(posedge core_clk) retain_req <= 1;
    repeat (4) @(posedge core_clk);
    @(negedge core_clk) `CHK({retained, cs2}, 2'b10)
    @(posedge core_clk) retain_req <= 0;
    rd(0, 20'haaaaa, 0, sh[20'haaaaa]);
    repeat (8) @(posedge core_clk);
    `CHK(exq.size(), 0)
    close_out;
  end
endmodule
`default_nettype wire
